// [rgtrc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module rgtrc_top #(
	parameter int SYMBOL_CYC    = rgtrc_pkg::SYMBOL_CYC,
	parameter int LEAD_UNIT_CYC = rgtrc_pkg::LEAD_UNIT_CYC,
	parameter int STEP_CYC      = rgtrc_pkg::GAIN_STEP_CYC
) (
	input  wire logic       ref_clk_i,            // Device clock, 125 MHz.
	input  wire logic       reset_n_i,            // Asynchronous reset, active low.
	input  wire logic [7:0] reg_addr_i,           // Register offset.
	input  wire logic [7:0] reg_wdata_i,          // Register write data.
	input  wire logic       reg_we_i,             // Register write strobe.
	input  wire logic       reg_re_i,             // Register read strobe.
	output logic      [7:0] reg_rdata_o,          // Read data, one cycle after the strobe.
	input  wire logic       sleep_tx_pin_i,       // Transmit launch pin.
	input  wire logic       auto_tx_req_i,        // Launch request from the auto modes.
	input  wire logic       auto_retry_i,         // Device sits in auto-retry transmit.
	input  wire logic       rx_listen_i,          // Receiver is listening.
	input  wire logic       shr_detect_i,         // Sync header found, one-cycle pulse.
	input  wire logic [9:0] rssi_i,               // Strength above base, tenths of a dB.
	input  wire logic       rx_frame_end_i,       // Received frame complete pulse.
	input  wire logic       tx_data_done_i,       // Last transmit data sent pulse.
	output logic      [3:0] rf_match_cap_code_o,  // Antenna matching capacitor code.
	output logic            rx_start_o,           // Frame reception begins, pulse.
	output logic            rx_busy_o,            // A frame is being received.
	output logic            pa_enable_o,          // Power amplifier enable.
	output logic      [1:0] pa_gain_o,            // Current PA gain code.
	output logic            pa_equalizer_en_o,    // PA linearizing equalizer on.
	output logic      [4:0] tx_power_reduction_o, // Output power reduction, dB.
	output logic            tx_data_start_o,      // First modulated data, pulse.
	output logic            tx_data_active_o,     // Modulated data being sent.
	output logic      [4:0] trx_state_o           // Reported status code.
);

	initial begin
		if (SYMBOL_CYC <= 4 * LEAD_UNIT_CYC || LEAD_UNIT_CYC < 1) begin
			$error("rgtrc_top: lead time does not fit in a symbol");
		end
	end

	typedef enum logic [2:0] {
		TS_OFF    = 3'b001,
		TS_LOCKED = 3'b010,
		TS_TX     = 3'b100
	} rgtrc_tstate_t;

	rgtrc_tstate_t state;
	logic [7:0]    tx_power;
	logic [7:0]    sync_gate;
	logic [7:0]    rf_ctrl_0;
	logic [7:0]    match_ctrl;
	logic          pin_prev;
	logic          launch;
	logic          cmd_wr;
	logic          rx_accept;
	logic [9:0]    thresh;

	rgtrc_ramp_if rp ();

	// Address decode used by the write and command logic; the read port decodes with its own case.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	assign cmd_wr = reg_we_i && hit(reg_addr_i, rgtrc_pkg::ADDR_COMMAND);

	// A launch from host command, pin edge or the auto modes, only when locked.
	assign launch = (state == TS_LOCKED) &&
		((cmd_wr && reg_wdata_i[rgtrc_pkg::CMD_LSB +: 5] == rgtrc_pkg::CMD_TX_LAUNCH) ||
		(sleep_tx_pin_i && !pin_prev) ||
		auto_tx_req_i);

	// Configuration registers; reserved bits of the sync gate stay zero.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_power   <= rgtrc_pkg::RST_TX_POWER;
			sync_gate  <= rgtrc_pkg::RST_SYNC_GATE;
			rf_ctrl_0  <= rgtrc_pkg::RST_RF_CTRL_0;
			match_ctrl <= rgtrc_pkg::RST_MATCH_CTRL;
		end else if (reg_we_i) begin
			if (hit(reg_addr_i, rgtrc_pkg::ADDR_TX_POWER)) begin
				tx_power <= reg_wdata_i;
			end
			if (hit(reg_addr_i, rgtrc_pkg::ADDR_SYNC_GATE)) begin
				sync_gate <= {reg_wdata_i[rgtrc_pkg::BLOCK_BIT], 3'h0, reg_wdata_i[rgtrc_pkg::THRESH_LSB +: 4]};
			end
			if (hit(reg_addr_i, rgtrc_pkg::ADDR_RF_CTRL_0)) begin
				rf_ctrl_0[5:0] <= reg_wdata_i[5:0];
				// Lead time takes effect outside an active transmission, or at any time in auto-retry.
				if (state != TS_TX || auto_retry_i) begin
					rf_ctrl_0[rgtrc_pkg::LEAD_LSB +: 2] <= reg_wdata_i[rgtrc_pkg::LEAD_LSB +: 2];
				end
			end
			if (hit(reg_addr_i, rgtrc_pkg::ADDR_MATCH_CTRL)) begin
				match_ctrl <= reg_wdata_i;
			end
		end
	end

	// Registered read port; unmapped offsets read zero.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_re_i) begin
			unique case (reg_addr_i)
				rgtrc_pkg::ADDR_STATUS:     reg_rdata_o <= {3'h0, trx_state_o};
				rgtrc_pkg::ADDR_TX_POWER:   reg_rdata_o <= tx_power;
				rgtrc_pkg::ADDR_SYNC_GATE:  reg_rdata_o <= sync_gate;
				rgtrc_pkg::ADDR_RF_CTRL_0:  reg_rdata_o <= rf_ctrl_0;
				rgtrc_pkg::ADDR_MATCH_CTRL: reg_rdata_o <= match_ctrl;
				default:                    reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// Transceiver state: off, synth-locked, transmitting.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state    <= TS_OFF;
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= sleep_tx_pin_i;
			unique case (state)
				TS_OFF: begin
					if (cmd_wr && reg_wdata_i[rgtrc_pkg::CMD_LSB +: 5] == rgtrc_pkg::CMD_SYNTH_LOCK) begin
						state <= TS_LOCKED;
					end
				end
				TS_LOCKED: begin
					if (launch) begin
						state <= TS_TX;
					end else if (cmd_wr && reg_wdata_i[rgtrc_pkg::CMD_LSB +: 5] == rgtrc_pkg::CMD_OFF) begin
						state <= TS_OFF;
					end
				end
				TS_TX: begin
					if (rp.ramp_done) begin
						state <= TS_LOCKED;
					end
				end
			endcase
		end
	end

	// Status code follows the state register one cycle later.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			trx_state_o <= rgtrc_pkg::STAT_OFF;
		end else begin
			unique case (state)
				TS_OFF:    trx_state_o <= rgtrc_pkg::STAT_OFF;
				TS_LOCKED: trx_state_o <= rgtrc_pkg::STAT_LOCKED;
				TS_TX:     trx_state_o <= rgtrc_pkg::STAT_TX;
			endcase
		end
	end

	// Sync header gate: threshold of 3.1 dB per count, zero means no gating.
	assign thresh = 10'(rgtrc_pkg::THRESH_STEP * 10'(sync_gate[rgtrc_pkg::THRESH_LSB +: 4]));
	assign rx_accept = rx_listen_i && shr_detect_i && !rx_busy_o && (state != TS_TX) &&
		!sync_gate[rgtrc_pkg::BLOCK_BIT] &&
		((sync_gate[rgtrc_pkg::THRESH_LSB +: 4] == 4'h0) || (rssi_i >= thresh));

	// The block bit is not looked at once a frame is running, so it completes.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_busy_o  <= 1'b0;
			rx_start_o <= 1'b0;
		end else begin
			rx_start_o <= rx_accept;
			if (rx_accept) begin
				rx_busy_o <= 1'b1;
			end else if (rx_frame_end_i) begin
				rx_busy_o <= 1'b0;
			end
		end
	end

	// Static settings driven to the analog side.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rf_match_cap_code_o  <= 4'h0;
			pa_equalizer_en_o    <= 1'b1;
			tx_power_reduction_o <= 5'h00;
		end else begin
			rf_match_cap_code_o  <= match_ctrl[rgtrc_pkg::MATCH_LSB +: 4];
			pa_equalizer_en_o    <= !tx_power[rgtrc_pkg::BOOST_BIT];
			tx_power_reduction_o <= tx_power[rgtrc_pkg::PWR_LSB +: 5];
		end
	end

	// Ramp sequencer connections.
	assign rp.launch      = launch;
	assign rp.lead_code   = rf_ctrl_0[rgtrc_pkg::LEAD_LSB +: 2];
	assign rp.gain_target = tx_power[rgtrc_pkg::GAIN_LSB +: 2];
	assign rp.data_done   = tx_data_done_i;

	rgtrc_ramp_seq #(
		.SYMBOL_CYC    (SYMBOL_CYC),
		.LEAD_UNIT_CYC (LEAD_UNIT_CYC),
		.STEP_CYC      (STEP_CYC)
	) u_seq (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.rp        (rp.seq)
	);

	assign pa_enable_o      = rp.pa_en;
	assign pa_gain_o        = rp.gain;
	assign tx_data_start_o  = rp.data_start;
	assign tx_data_active_o = rp.data_active;

	chk_block_no_start: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		sync_gate[rgtrc_pkg::BLOCK_BIT] && !rx_busy_o |=> !rx_start_o)
		else $error("reception started while blocked");

	chk_busy_survives: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		rx_busy_o && !rx_frame_end_i |=> rx_busy_o)
		else $error("reception dropped without frame end");

	chk_threshold_gate: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		rx_start_o |-> $past(sync_gate[3:0]) == 4'h0 || $past(rssi_i) >= 10'(10'h01f * 10'($past(sync_gate[3:0]))))
		else $error("weak frame accepted");

	chk_launch_status: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		launch |-> trx_state_o == rgtrc_pkg::STAT_LOCKED ##2 trx_state_o == rgtrc_pkg::STAT_TX)
		else $error("status not moved to transmitting");

	chk_launch_only_locked: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(state == TS_TX) |-> $past(state) == TS_LOCKED)
		else $error("transmission from wrong state");

	chk_equalizer_boost: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$past(tx_power[7]) |-> !pa_equalizer_en_o)
		else $error("equalizer on in boost mode");

	chk_match_code: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(pa_enable_o) |-> rf_match_cap_code_o == $past(match_ctrl[7:4]))
		else $error("match code not applied during transmit");

endmodule
`default_nettype wire

// [rgtrc_pkg.sv]
package rgtrc_pkg;

	// Register offsets.
	localparam logic [7:0] ADDR_STATUS     = 8'h01;
	localparam logic [7:0] ADDR_COMMAND    = 8'h02;
	localparam logic [7:0] ADDR_TX_POWER   = 8'h05;
	localparam logic [7:0] ADDR_SYNC_GATE  = 8'h15;
	localparam logic [7:0] ADDR_RF_CTRL_0  = 8'h16;
	localparam logic [7:0] ADDR_MATCH_CTRL = 8'h19;

	// Reset values.
	localparam logic [7:0] RST_TX_POWER   = 8'h60;
	localparam logic [7:0] RST_SYNC_GATE  = 8'h00;
	localparam logic [7:0] RST_RF_CTRL_0  = 8'h31;
	localparam logic [7:0] RST_MATCH_CTRL = 8'h00;

	// Field positions.
	localparam int MATCH_LSB      = 4;
	localparam int BLOCK_BIT      = 7;
	localparam int THRESH_LSB     = 0;
	localparam int LEAD_LSB       = 6;
	localparam int BOOST_BIT      = 7;
	localparam int GAIN_LSB       = 5;
	localparam int PWR_LSB        = 0;
	localparam int CMD_LSB        = 0;

	// Command codes written to the command field.
	localparam logic [4:0] CMD_TX_LAUNCH  = 5'h01;
	localparam logic [4:0] CMD_SYNTH_LOCK = 5'h02;
	localparam logic [4:0] CMD_OFF        = 5'h03;

	// Status codes reported in the status register.
	localparam logic [4:0] STAT_OFF    = 5'h01;
	localparam logic [4:0] STAT_LOCKED = 5'h02;
	localparam logic [4:0] STAT_TX     = 5'h03;

	// Timing, in nanoseconds, and the clock period.
	localparam int CLK_NS       = 8;
	localparam int SYMBOL_NS    = 16000;
	localparam int LEAD_UNIT_NS = 2000;
	localparam int GAIN_STEP_NS = 500;
	localparam int SYMBOL_CYC   = SYMBOL_NS / CLK_NS;
	localparam int LEAD_UNIT_CYC = LEAD_UNIT_NS / CLK_NS;
	localparam int GAIN_STEP_CYC = GAIN_STEP_NS / CLK_NS;

	// Threshold step of 3.1 dB in tenths of a dB.
	localparam logic [9:0] THRESH_STEP = 10'h01f;

endpackage

// [rgtrc_ramp_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface rgtrc_ramp_if;
	logic       launch;
	logic [1:0] lead_code;
	logic [1:0] gain_target;
	logic       data_done;
	logic       pa_en;
	logic [1:0] gain;
	logic       data_start;
	logic       data_active;
	logic       ramp_done;

	modport ctrl (output launch, lead_code, gain_target, data_done,
		input pa_en, gain, data_start, data_active, ramp_done);
	modport seq (input launch, lead_code, gain_target, data_done,
		output pa_en, gain, data_start, data_active, ramp_done);
endinterface
`default_nettype wire

// [rgtrc_ramp_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module rgtrc_ramp_seq #(
	parameter int SYMBOL_CYC    = rgtrc_pkg::SYMBOL_CYC,
	parameter int LEAD_UNIT_CYC = rgtrc_pkg::LEAD_UNIT_CYC,
	parameter int STEP_CYC      = rgtrc_pkg::GAIN_STEP_CYC
) (
	input  wire logic  ref_clk_i,   // Device clock.
	input  wire logic  reset_n_i,   // Asynchronous reset, active low.
	rgtrc_ramp_if.seq  rp           // Ramp requests and results.
);

	// The whole lead must fit inside the settling symbol, and counters are 16 bits.
	initial begin
		if (SYMBOL_CYC <= 4 * LEAD_UNIT_CYC || SYMBOL_CYC > 65535 || STEP_CYC < 1) begin
			$error("rgtrc_ramp_seq: timing parameters out of range");
		end
	end

	typedef enum logic [3:0] {
		RS_IDLE   = 4'b0001,
		RS_SETTLE = 4'b0010,
		RS_DATA   = 4'b0100,
		RS_DOWN   = 4'b1000
	} rgtrc_rstate_t;

	rgtrc_rstate_t state;
	logic [15:0]   cnt;
	logic [15:0]   step_cnt;
	logic [1:0]    lead_hold;
	logic [1:0]    target_hold;
	logic [15:0]   pa_on_at;

	// PA switches on at this settle count; the extra one keeps the PA edge a full lead ahead of data start.
	assign pa_on_at = 16'(SYMBOL_CYC - 1 - LEAD_UNIT_CYC * (32'(lead_hold) + 1));

	// Sequence state and launch-time sampling of lead and gain target.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state       <= RS_IDLE;
			lead_hold   <= 2'h0;
			target_hold <= 2'h0;
			cnt         <= 16'h0000;
		end else begin
			unique case (state)
				RS_IDLE: begin
					if (rp.launch) begin
						lead_hold   <= rp.lead_code;
						target_hold <= rp.gain_target;
						cnt         <= 16'h0000;
						state       <= RS_SETTLE;
					end
				end
				RS_SETTLE: begin
					cnt <= cnt + 16'h0001;
					if (cnt == 16'(SYMBOL_CYC - 1)) begin
						state <= RS_DATA;
					end
				end
				RS_DATA: begin
					if (rp.data_done) begin
						state <= RS_DOWN;
					end
				end
				RS_DOWN: begin
					if (!rp.pa_en) begin
						state <= RS_IDLE;
					end
				end
			endcase
		end
	end

	// Data start pulse and data-active level; data stops first on the way down.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rp.data_start  <= 1'b0;
			rp.data_active <= 1'b0;
		end else begin
			rp.data_start <= (state == RS_SETTLE) && (cnt == 16'(SYMBOL_CYC - 1));
			if (state == RS_SETTLE && cnt == 16'(SYMBOL_CYC - 1)) begin
				rp.data_active <= 1'b1;
			end else if (state == RS_DATA && rp.data_done) begin
				rp.data_active <= 1'b0;
			end
		end
	end

	// PA enable and gain: up from zero in steps, down in steps, PA off last.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rp.pa_en  <= 1'b0;
			rp.gain   <= 2'h0;
			step_cnt  <= 16'h0000;
		end else begin
			if (state == RS_SETTLE && cnt == pa_on_at && !rp.pa_en) begin
				rp.pa_en <= 1'b1;
				rp.gain  <= 2'h0;
				step_cnt <= 16'h0000;
			end else if (rp.pa_en && state != RS_DOWN && rp.gain != target_hold) begin
				if (step_cnt == 16'(STEP_CYC - 1)) begin
					step_cnt <= 16'h0000;
					rp.gain  <= rp.gain + 2'h1;
				end else begin
					step_cnt <= step_cnt + 16'h0001;
				end
			end else if (state == RS_DOWN && rp.pa_en) begin
				if (step_cnt == 16'(STEP_CYC - 1)) begin
					step_cnt <= 16'h0000;
					if (rp.gain == 2'h0) begin
						rp.pa_en <= 1'b0;
					end else begin
						rp.gain <= rp.gain - 2'h1;
					end
				end else begin
					step_cnt <= step_cnt + 16'h0001;
				end
			end else begin
				step_cnt <= 16'h0000;
			end
		end
	end

	// One-cycle pulse when the ramp down has finished.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rp.ramp_done <= 1'b0;
		end else begin
			rp.ramp_done <= (state == RS_DOWN) && !rp.pa_en;
		end
	end

	// Helper ages for the checks below.
	logic [15:0] launch_age;
	logic [15:0] pa_age;
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			launch_age <= 16'h0000;
			pa_age     <= 16'h0000;
		end else begin
			launch_age <= (state == RS_IDLE && rp.launch) ? 16'h0001 : launch_age + 16'h0001;
			pa_age     <= rp.pa_en ? pa_age + 16'h0001 : 16'h0000;
		end
	end

	chk_data_after_symbol: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		rp.data_start |-> launch_age == 16'(SYMBOL_CYC + 1))
		else $error("data start not one symbol after launch");

	chk_pa_lead_time: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		rp.data_start |-> pa_age == 16'(LEAD_UNIT_CYC * (32'(lead_hold) + 1)))
		else $error("PA lead time wrong at data start");

	chk_gain_starts_low: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(rp.pa_en) |-> rp.gain == 2'h0)
		else $error("PA enabled at nonzero gain");

	chk_pa_off_last: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$fell(rp.pa_en) |-> $past(rp.gain) == 2'h0 && !rp.data_active)
		else $error("PA switched off before gain ramped down");

	chk_gain_held_target: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		state == RS_SETTLE |=> $stable(target_hold) && $stable(lead_hold))
		else $error("ramp settings changed during ramp");

endmodule
`default_nettype wire

// [rgtrc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host side of the register port and the launch pin.
module rgtrc_host_model (
	input  wire logic [7:0] reg_rdata_i,    // Read data from the device.
	input  wire logic       ref_clk_i,      // Device clock.
	output var logic  [7:0] reg_addr_o,     // Register offset.
	output var logic  [7:0] reg_wdata_o,    // Write data.
	output var logic        reg_we_o,       // Write strobe.
	output var logic        reg_re_o,       // Read strobe.
	output var logic        sleep_tx_pin_o  // Launch pin.
);
	// Everything starts idle so the device sees no request during reset.
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		reg_we_o = 1'b0;
		reg_re_o = 1'b0;
		sleep_tx_pin_o = 1'b0;
	end

	// A released bus shows inverted values, so a stale address can never pass for a live one.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_we_o = 1'b1;
		@(posedge ref_clk_i);
		#1;
		reg_we_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask

	// Read data is taken one cycle after the strobe edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		#1;
		reg_addr_o = a;
		reg_re_o = 1'b1;
		@(posedge ref_clk_i);
		#1;
		reg_re_o = 1'b0;
		reg_addr_o = ~a;
		@(posedge ref_clk_i);
		#1;
		d = reg_rdata_i;
	endtask

	// The pin is raised without checking the reported state, and held for two cycles.
	task automatic launch_pin();
		@(posedge ref_clk_i);
		#1;
		sleep_tx_pin_o = 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#1;
		sleep_tx_pin_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// [rx_gate_tx_ramp_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module rx_gate_tx_ramp_control_tb;
	localparam int SYM = 40;
	localparam int LU = 4;
	localparam int STEP = 2;
	logic       ref_clk, reset_n, we, re, pin, auto_req, listen, shr, fend, done;
	logic [7:0] addr, wdata, rdata;
	logic [9:0] rssi;
	logic [3:0] match;
	logic       rx_start, rx_busy, pa_en, eq_en, ds, da;
	logic [1:0] gain;
	logic [4:0] pwr, state;
	int         n_errors, samples_checked, cyc, t_l, t_pa, t_ds;
	logic [1:0] g_pa, g_off, g_q;
	logic       pa_q, pin_q;
	logic       aret;

	rgtrc_host_model host (.reg_rdata_i(rdata), .ref_clk_i(ref_clk), .reg_addr_o(addr), .reg_wdata_o(wdata),
		.reg_we_o(we), .reg_re_o(re), .sleep_tx_pin_o(pin));

	rgtrc_top #(.SYMBOL_CYC(SYM), .LEAD_UNIT_CYC(LU), .STEP_CYC(STEP)) DUT (.ref_clk_i(ref_clk),
		.reset_n_i(reset_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
		.reg_rdata_o(rdata), .sleep_tx_pin_i(pin), .auto_tx_req_i(auto_req), .auto_retry_i(aret),
		.rx_listen_i(listen), .shr_detect_i(shr), .rssi_i(rssi), .rx_frame_end_i(fend),
		.tx_data_done_i(done), .rf_match_cap_code_o(match), .rx_start_o(rx_start), .rx_busy_o(rx_busy),
		.pa_enable_o(pa_en), .pa_gain_o(gain), .pa_equalizer_en_o(eq_en), .tx_power_reduction_o(pwr),
		.tx_data_start_o(ds), .tx_data_active_o(da), .trx_state_o(state));

	// Free-running clock, 8 ns period.
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// Edge monitor: timestamps launch, amplifier and data events; a stuck run is cut off here.
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if ((we && addr == rgtrc_pkg::ADDR_COMMAND && wdata[4:0] == rgtrc_pkg::CMD_TX_LAUNCH) || (pin && !pin_q) || auto_req)
			t_l = cyc;
		if (pa_en && !pa_q)
			t_pa = cyc;
		if (pa_en && !pa_q)
			g_pa = gain;
		if (!pa_en && pa_q)
			g_off = g_q;
		if (ds)
			t_ds = cyc;
		pa_q = pa_en;
		g_q = gain;
		pin_q = pin;
		if (cyc > 20000) begin
			n_errors = n_errors + 1;
			report_and_stop();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Bounded wait for a reported status; a miss counts as a mismatch.
	task automatic wait_state(input logic [4:0] s);
		int k;
		k = 0;
		while (state !== s && k < 200) begin
			@(posedge ref_clk);
			#1;
			k = k + 1;
		end
		chk({11'h000, state}, {11'h000, s});
	endtask

	// Reset values, the unmapped offset, and a launch attempted while off.
	task automatic t_reset_vals();
		logic [7:0] a [5];
		logic [7:0] e [5];
		logic [7:0] d;
		a = '{8'h05, 8'h15, 8'h16, 8'h19, 8'h30};
		e = '{8'h60, 8'h00, 8'h31, 8'h00, 8'h00};
		chk({15'h0000, eq_en}, 16'h0001);
		for (int i = 0; i < 5; i++) begin
			host.rd(a[i], d);
			chk({8'h00, d}, {8'h00, e[i]});
		end
		host.wr(rgtrc_pkg::ADDR_COMMAND, {3'h0, rgtrc_pkg::CMD_TX_LAUNCH});
		repeat (4) @(posedge ref_clk);
		#1;
		chk({11'h000, state}, {11'h000, rgtrc_pkg::STAT_OFF});
		chk({15'h0000, pa_en}, 16'h0000);
	endtask

	// Matching code, reserved gate bits, boost and power reduction fields.
	task automatic t_fields();
		logic [7:0] d;
		host.wr(rgtrc_pkg::ADDR_MATCH_CTRL, 8'ha5);
		@(posedge ref_clk);
		#1;
		chk({12'h000, match}, 16'h000a);
		host.rd(rgtrc_pkg::ADDR_MATCH_CTRL, d);
		chk({8'h00, d}, 16'h00a5);
		host.wr(rgtrc_pkg::ADDR_SYNC_GATE, 8'h7f);
		host.rd(rgtrc_pkg::ADDR_SYNC_GATE, d);
		chk({8'h00, d}, 16'h000f);
		host.wr(rgtrc_pkg::ADDR_SYNC_GATE, 8'h00);
		host.wr(rgtrc_pkg::ADDR_TX_POWER, 8'h9f);
		@(posedge ref_clk);
		#1;
		chk({10'h000, eq_en, pwr}, 16'h001f);
		host.wr(rgtrc_pkg::ADDR_TX_POWER, 8'h05);
		@(posedge ref_clk);
		#1;
		chk({10'h000, eq_en, pwr}, 16'h0025);
	endtask

	// One sync header at a given strength; optionally the block bit is set mid-frame.
	task automatic rx_try(input logic [9:0] r, input logic exp, input logic blk);
		@(posedge ref_clk);
		#1;
		rssi = r;
		shr = 1'b1;
		@(posedge ref_clk);
		#1;
		shr = 1'b0;
		chk({15'h0000, rx_start}, {15'h0000, exp});
		if (exp) begin
			if (blk)
				host.wr(rgtrc_pkg::ADDR_SYNC_GATE, 8'h82);
			chk({15'h0000, rx_busy}, 16'h0001);
			@(posedge ref_clk);
			#1;
			fend = 1'b1;
			@(posedge ref_clk);
			#1;
			fend = 1'b0;
			chk({15'h0000, rx_busy}, 16'h0000);
		end
	endtask

	task automatic t_receive();
		rx_try(10'h000, 1'b1, 1'b0);
		host.wr(rgtrc_pkg::ADDR_SYNC_GATE, 8'h02);
		rx_try(10'h03d, 1'b0, 1'b0);
		rx_try(10'h03e, 1'b1, 1'b1);
		rx_try(10'h3ff, 1'b0, 1'b0);
		host.wr(rgtrc_pkg::ADDR_SYNC_GATE, 8'h00);
		rx_try(10'h001, 1'b1, 1'b0);
	endtask

	// Full ramp: launch by command, pin or auto request; settings rewritten mid-flight must not apply, except the lead field in auto-retry.
	task automatic tx_run(input int m, input logic [1:0] lead, input logic [1:0] g);
		logic [7:0] d;
		host.wr(rgtrc_pkg::ADDR_RF_CTRL_0, {lead, 6'h31});
		host.wr(rgtrc_pkg::ADDR_TX_POWER, {1'b0, g, 5'h00});
		host.wr(rgtrc_pkg::ADDR_COMMAND, {3'h0, rgtrc_pkg::CMD_SYNTH_LOCK});
		wait_state(rgtrc_pkg::STAT_LOCKED);
		if (m == 0)
			host.wr(rgtrc_pkg::ADDR_COMMAND, {3'h0, rgtrc_pkg::CMD_TX_LAUNCH});
		else if (m == 1)
			host.launch_pin();
		else begin
			@(posedge ref_clk);
			#1;
			aret = 1'b1;
			auto_req = 1'b1;
			@(posedge ref_clk);
			#1;
			auto_req = 1'b0;
		end
		wait_state(rgtrc_pkg::STAT_TX);
		host.wr(rgtrc_pkg::ADDR_TX_POWER, 8'h00);
		host.wr(rgtrc_pkg::ADDR_RF_CTRL_0, 8'h31);
		while (!da && cyc < 20000)
			@(posedge ref_clk);
		repeat (8) @(posedge ref_clk);
		#1;
		chk(16'(t_ds - t_l), 16'(SYM + 1));
		chk(16'(t_ds - t_pa), 16'(LU * (lead + 1)));
		chk({14'h0000, g_pa}, 16'h0000);
		chk({14'h0000, gain}, {14'h0000, g});
		chk({15'h0000, da}, 16'h0001);
		done = 1'b1;
		@(posedge ref_clk);
		#1;
		done = 1'b0;
		chk({15'h0000, da}, 16'h0000);
		wait_state(rgtrc_pkg::STAT_LOCKED);
		chk({14'h0000, g_off}, 16'h0000);
		chk({15'h0000, pa_en}, 16'h0000);
		host.rd(rgtrc_pkg::ADDR_RF_CTRL_0, d);
		chk({8'h00, d}, {8'h00, ((m == 2) ? 2'h0 : lead), 6'h31});
		aret = 1'b0;
	endtask

	// Main sequence: reset held for sixteen cycles, then each scenario in turn.
	initial begin
		{reset_n, auto_req, listen, shr, fend, done} = 6'h00;
		rssi = 10'h000;
		n_errors = 0;
		samples_checked = 0;
		cyc = 0;
		t_l = 0;
		t_pa = 0;
		t_ds = 0;
		aret = 1'b0;
		{g_pa, g_off, g_q, pa_q, pin_q} = 8'h00;
		repeat (16) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		listen = 1'b1;
		t_reset_vals();
		t_fields();
		t_receive();
		tx_run(0, 2'h3, 2'h3);
		tx_run(1, 2'h0, 2'h1);
		tx_run(2, 2'h1, 2'h2);
		tx_run(0, 2'h2, 2'h2);
		report_and_stop();
	end
endmodule
`default_nettype wire
